// ### src/pfp_core.sv
`timescale 1ns/1ps
`include "pfp_map.svh"
`default_nettype none
module pfp_core #(
  parameter logic [6:0] SLAVE_ADDR = 7'h58,
  parameter bit PIN_ACTIVE_HIGH = 1'b1,
  parameter int RESTART_CYC = (`PFP_RESTART_NS * `PFP_CLK_MHZ + 999) / 1000
) (
  input wire logic core_clk, // System clock
  input wire logic resetn, // Async reset, low
  input wire logic clk_en, // Freezes all state when low
  input wire logic scl_in, // Bus clock pin
  input wire logic sda_in, // Bus data pin level
  output logic sda_out, // Bus data drive value
  output logic sda_oe, // Bus data drive enable
  output logic alert_oe, // Alert pull-down enable
  input wire logic on_off_input_pin, // On/off pin
  input wire logic op_on, // Operation on bit
  input wire logic latch_mode, // Faults latch off
  input wire logic [3:0] fault_raw, // Fault conditions
  input wire logic [7:0] ext_rdata, // Read data, other codes
  output pfp_pkg::pfp_wr_s ext_wr, // Write to other codes
  output logic ext_wr_vld, // Write strobe
  output pfp_pkg::pfp_nv_req_s nv_req, // EEPROM request
  output logic nv_req_vld, // EEPROM request strobe
  input wire logic nv_done, // EEPROM done pulse
  input wire logic nv_fail, // EEPROM fail with done
  input wire logic [7:0] nv_rdata, // Restored guard byte
  output logic switch_en, // Drivers enabled
  output logic low_side_hold, // Low-side held on
  output logic latched_off // Off after a fault
);
  typedef enum logic [2:0] {
    S_IDLE, S_RX, S_ACK, S_TX, S_TXACK
  } pfp_bus_e;

  // ====================================
  // Code tables
  function automatic logic code_known(input logic [7:0] c);
    case (c)
      8'h01, 8'h02, 8'h03, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
      8'h20, 8'h21, 8'h22, 8'h25, 8'h26, 8'h78, 8'h79, 8'h7E,
      8'hA4, 8'hA5, 8'hD0, 8'hD4, 8'hD5, 8'hD6, 8'hD7,
      8'hFC: code_known = 1'b1;
      default: code_known = 1'b0;
    endcase
  endfunction : code_known

  function automatic logic code_ro(input logic [7:0] c);
    case (c)
      8'h20, 8'h78, 8'h79, 8'h7E, 8'hA4, 8'hA5,
      8'hFC: code_ro = 1'b1;
      default: code_ro = 1'b0;
    endcase
  endfunction : code_ro

  // Guard decode, used for every incoming write
  function automatic logic guard_ok(input logic [2:0] g,
                                    input logic [7:0] c);
    if (g[2]) begin
      guard_ok = (c == `PFP_CMD_GUARD);
    end else if (g[1]) begin
      guard_ok = (c == `PFP_CMD_GUARD) ||
                 (c == `PFP_CMD_OPERATION);
    end else if (g[0]) begin
      guard_ok = (c == `PFP_CMD_GUARD) || (c == `PFP_CMD_OPERATION) ||
                 (c == `PFP_CMD_ONOFF);
    end else begin
      guard_ok = 1'b1;
    end
  endfunction : guard_ok

  // ====================================
  // Pin synchronisers
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [1:0] pin_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      pin_q <= 2'h0;
    end else if (clk_en) begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
      pin_q <= {pin_q[0], on_off_input_pin};
    end
  end
  // Edges only from stages 1 and 2, stage 0 stays a pure synchroniser
  logic scl_rise, scl_fall, bus_start, bus_stop, pin_on;
  assign scl_rise = scl_q[1] && !scl_q[2];
  assign scl_fall = !scl_q[1] && scl_q[2];
  assign bus_start = scl_q[1] && !sda_q[1] && sda_q[2];
  assign bus_stop = scl_q[1] && sda_q[1] && !sda_q[2];
  assign pin_on = (pin_q[1] == PIN_ACTIVE_HIGH);

  // ====================================
  // Bus target engine
  pfp_bus_e st;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [1:0] byte_idx;
  logic rx_full, tx_mode, fail_nack, nv_busy;
  logic [7:0] cmd_code, cmd_data, tx_byte;
  logic have_cmd, have_data, exec;
  logic [2:0] write_guard;
  logic [7:0] on_off_cfg, status_byte, status_cml;

  // Read mux; reads never pass through the guard
  logic [7:0] rd_byte;
  always_comb begin
    case (cmd_code)
      `PFP_CMD_GUARD: rd_byte = {write_guard, 5'h00};
      `PFP_CMD_ONOFF: rd_byte = on_off_cfg;
      `PFP_CMD_STAT_BYTE, `PFP_CMD_STAT_WORD: rd_byte = status_byte;
      `PFP_CMD_STAT_CML: rd_byte = status_cml;
      default: rd_byte = ext_rdata;
    endcase
  end

  // Byte framing, ack and shifting
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= S_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      byte_idx <= 2'h0;
      rx_full <= 1'b0;
      tx_mode <= 1'b0;
      tx_byte <= 8'h00;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      cmd_code <= 8'h00;
      cmd_data <= 8'h00;
      have_cmd <= 1'b0;
      have_data <= 1'b0;
    end else if (clk_en) begin
      if (bus_start) begin
        st <= S_RX;
        bit_cnt <= 3'h0;
        byte_idx <= 2'h0;
        rx_full <= 1'b0;
        tx_mode <= 1'b0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        st <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st)
          S_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_q[1]};
              bit_cnt <= bit_cnt + 3'h1;
              rx_full <= (bit_cnt == 3'h7);
            end else if (scl_fall && rx_full) begin
              rx_full <= 1'b0;
              st <= S_ACK;
              if (byte_idx == 2'h0) begin
                // Busy copy or failed program answers with NACK
                if (shreg[7:1] == SLAVE_ADDR && !nv_busy && !fail_nack) begin
                  sda_oe <= 1'b1;
                  tx_mode <= shreg[0];
                  tx_byte <= rd_byte;
                  if (!shreg[0]) begin
                    have_cmd <= 1'b0;
                    have_data <= 1'b0;
                  end
                end else begin
                  st <= S_IDLE;
                end
              end else if (byte_idx == 2'h1) begin
                sda_oe <= 1'b1;
                cmd_code <= shreg;
                have_cmd <= 1'b1;
              end else begin
                sda_oe <= 1'b1;
                cmd_data <= shreg;
                have_data <= 1'b1;
              end
              if (byte_idx != 2'h3) begin
                byte_idx <= byte_idx + 2'h1;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (tx_mode) begin
                st <= S_TX;
                sda_oe <= !tx_byte[7];
                tx_byte <= {tx_byte[6:0], 1'b0};
              end else begin
                st <= S_RX;
                sda_oe <= 1'b0;
              end
            end
          end
          S_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 3'h1;
            end else if (scl_fall) begin
              if (bit_cnt == 3'h0) begin
                st <= S_TXACK;
                sda_oe <= 1'b0;
              end else begin
                sda_oe <= !tx_byte[7];
                tx_byte <= {tx_byte[6:0], 1'b0};
              end
            end
          end
          S_TXACK: begin
            // Single-byte reads only; go idle on the rise of the host ack clock
            if (scl_rise) begin
              st <= S_IDLE;
            end
          end
          default: st <= S_IDLE;
        endcase
      end
    end
  end

  // Command runs at the stop of a write transaction
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      exec <= 1'b0;
    end else if (clk_en) begin
      exec <= bus_stop && have_cmd && !tx_mode && st != S_IDLE;
    end
  end

  // ====================================
  // Command decode
  logic is_send, wr_ok, guard_multi, one_ok, cml_ev, ivd_ev;
  assign is_send = (cmd_code == `PFP_CMD_CLEAR) ||
                   (cmd_code == `PFP_CMD_STORE_ALL) ||
                   (cmd_code == `PFP_CMD_REST_ALL);
  assign wr_ok = guard_ok(write_guard, cmd_code);
  assign guard_multi = (32'(cmd_data[7]) + 32'(cmd_data[6]) +
                        32'(cmd_data[5])) > 32'd1;
  assign one_ok = code_known(cmd_data) && !code_ro(cmd_data);
  logic do_clear, do_guard, do_nv;
  pfp_pkg::pfp_nv_op_e nv_op;
  always_comb begin
    do_clear = 1'b0;
    do_guard = 1'b0;
    do_nv = 1'b0;
    nv_op = pfp_pkg::NV_STORE_ALL;
    cml_ev = 1'b0;
    ivd_ev = 1'b0;
    if (exec) begin
      if (!wr_ok || (is_send == have_data)) begin
        cml_ev = 1'b1;
      end else begin
        case (cmd_code)
          `PFP_CMD_CLEAR: do_clear = 1'b1;
          `PFP_CMD_GUARD: begin
            do_guard = !guard_multi;
            cml_ev = guard_multi;
            ivd_ev = guard_multi;
          end
          `PFP_CMD_STORE_ALL: begin
            do_nv = 1'b1;
            nv_op = pfp_pkg::NV_STORE_ALL;
          end
          `PFP_CMD_REST_ALL: begin
            do_nv = 1'b1;
            nv_op = pfp_pkg::NV_REST_ALL;
          end
          `PFP_CMD_STORE_ONE, `PFP_CMD_REST_ONE: begin
            do_nv = one_ok;
            cml_ev = !one_ok;
            ivd_ev = !one_ok;
            nv_op = (cmd_code == `PFP_CMD_STORE_ONE) ?
                    pfp_pkg::NV_STORE_ONE : pfp_pkg::NV_REST_ONE;
          end
          default: begin
            cml_ev = !code_known(cmd_code) || code_ro(cmd_code);
          end
        endcase
      end
    end
  end

  // Guard and on/off config storage
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      write_guard <= `PFP_GUARD_RST;
      on_off_cfg <= `PFP_ONOFF_RST;
    end else if (clk_en) begin
      if (do_guard) begin
        write_guard <= cmd_data[7:5];
      end else if (nv_done && !nv_fail && nv_req.op == pfp_pkg::NV_REST_ONE &&
                   nv_req.code == `PFP_CMD_GUARD) begin
        write_guard <= nv_rdata[7:5];
      end
      // Off-action bit stays 1 whatever is written
      if (exec && wr_ok && have_data && cmd_code == `PFP_CMD_ONOFF) begin
        on_off_cfg <= {3'h0, cmd_data[4:1], 1'b1};
      end
    end
  end

  // Pass other permitted writes out to the register file
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ext_wr <= '0;
      ext_wr_vld <= 1'b0;
    end else if (clk_en) begin
      // Codes held in this block never leak to the register file
      ext_wr_vld <= exec && wr_ok && have_data && !is_send &&
                    code_known(cmd_code) && !code_ro(cmd_code) &&
                    !(cmd_code inside {`PFP_CMD_ONOFF, `PFP_CMD_GUARD,
                                       `PFP_CMD_STORE_ONE, `PFP_CMD_REST_ONE});
      ext_wr <= '{code: cmd_code, data: cmd_data};
    end
  end

  // ====================================
  // EEPROM request sequencing
  logic store_run;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      nv_req <= '0;
      nv_req_vld <= 1'b0;
      nv_busy <= 1'b0;
      fail_nack <= 1'b0;
    end else if (clk_en) begin
      nv_req_vld <= do_nv && !nv_busy;
      if (do_nv && !nv_busy) begin
        nv_req <= '{op: nv_op, code: cmd_data};
        nv_busy <= 1'b1;
      end else if (nv_done) begin
        nv_busy <= 1'b0;
      end
      // A failed store refuses the next address byte once
      if (nv_done && nv_fail && !store_run_n()) begin
        fail_nack <= 1'b1;
      end else if (bus_stop) begin
        fail_nack <= 1'b0;
      end
    end
  end
  function automatic logic store_run_n();
    store_run_n = (nv_req.op == pfp_pkg::NV_REST_ALL) ||
                  (nv_req.op == pfp_pkg::NV_REST_ONE);
  endfunction : store_run_n
  assign store_run = nv_busy && !store_run_n();

  // ====================================
  // Status flags; a raised fault beats a clear in the same cycle
  logic [3:0] fault_seen;
  logic store_fail;
  assign fault_seen = store_run ? 4'h0 : fault_raw;
  assign store_fail = nv_done && nv_fail && !store_run_n();
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status_byte <= 8'h00;
      status_cml <= 8'h00;
    end else if (clk_en) begin
      for (int i = 0; i < 4; i++) begin
        if (fault_seen[i]) begin
          status_byte[i + 2] <= 1'b1;
        end else if (do_clear) begin
          status_byte[i + 2] <= 1'b0;
        end
      end
      if (cml_ev || store_fail) begin
        status_byte[`PFP_SB_CML] <= 1'b1;
      end else if (do_clear) begin
        status_byte[`PFP_SB_CML] <= 1'b0;
      end
      if (ivd_ev) begin
        status_cml[`PFP_CML_IVD] <= 1'b1;
      end else if (do_clear) begin
        status_cml[`PFP_CML_IVD] <= 1'b0;
      end
      if (store_fail) begin
        status_cml[`PFP_CML_OTH] <= 1'b1;
      end else if (do_clear) begin
        status_cml[`PFP_CML_OTH] <= 1'b0;
      end
    end
  end

  // Alert follows any status bit, so a clear releases it unless a fault still stands
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      alert_oe <= 1'b0;
    end else if (clk_en) begin
      alert_oe <= (|status_byte) || (|status_cml);
    end
  end

  // ====================================
  // Switching control
  logic want_on, restore_go;
  logic [15:0] hold_cnt;
  assign want_on = !on_off_cfg[`PFP_ONOFF_PU] ||
                   ((!on_off_cfg[`PFP_ONOFF_CMD] || op_on) &&
                    (!on_off_cfg[`PFP_ONOFF_CPR] || pin_on));
  assign restore_go = do_nv && !nv_busy && (nv_op == pfp_pkg::NV_REST_ALL ||
                                            nv_op == pfp_pkg::NV_REST_ONE);

  // Latch-off survives a clear; a restore or pin off lifts it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      latched_off <= 1'b0;
    end else if (clk_en) begin
      if (restore_go || !want_on) begin
        latched_off <= 1'b0;
      end else if (switch_en && latch_mode && |fault_seen) begin
        latched_off <= 1'b1;
      end
    end
  end

  // Restore while running drops the drivers, holds low side, restarts
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hold_cnt <= 16'h0000;
      low_side_hold <= 1'b0;
    end else if (clk_en) begin
      if (restore_go && switch_en) begin
        hold_cnt <= 16'(RESTART_CYC);
        low_side_hold <= 1'b1;
      end else if (hold_cnt != 16'h0000) begin
        hold_cnt <= hold_cnt - 16'h0001;
        low_side_hold <= (hold_cnt != 16'h0001);
      end
    end
  end

  // Pin off removes drive on the third edge, no soft stop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      switch_en <= 1'b0;
    end else if (clk_en) begin
      switch_en <= want_on && !latched_off && hold_cnt == 16'h0000 &&
                   !(restore_go && switch_en) &&
                   !(latch_mode && |fault_seen);
    end
  end
endmodule : pfp_core
`default_nettype wire

// ### src/pfp_map.svh
`ifndef PFP_MAP_SVH
`define PFP_MAP_SVH
// ====================================
// Command codes
`define PFP_CMD_OPERATION 8'h01
`define PFP_CMD_ONOFF 8'h02
`define PFP_CMD_CLEAR 8'h03
`define PFP_CMD_GUARD 8'h10
`define PFP_CMD_STORE_ALL 8'h11
`define PFP_CMD_REST_ALL 8'h12
`define PFP_CMD_STORE_ONE 8'h13
`define PFP_CMD_REST_ONE 8'h14
`define PFP_CMD_STAT_BYTE 8'h78
`define PFP_CMD_STAT_WORD 8'h79
`define PFP_CMD_STAT_CML 8'h7E
// ====================================
// Field positions
`define PFP_GUARD_B7 7
`define PFP_GUARD_B6 6
`define PFP_GUARD_B5 5
`define PFP_SB_CML 1
`define PFP_CML_IVD 6
`define PFP_CML_OTH 1
`define PFP_ONOFF_PU 4
`define PFP_ONOFF_CMD 3
`define PFP_ONOFF_CPR 2
`define PFP_ONOFF_CPA 0
// ====================================
// Reset values and timing
`define PFP_GUARD_RST 3'h0
`define PFP_ONOFF_RST 8'h17
`define PFP_CLK_MHZ 40
`define PFP_RESTART_NS 100000
`endif

// ### src/pfp_pkg.sv
`default_nettype none
package pfp_pkg;
  // ====================================
  // Types
  typedef enum logic [1:0] {
    NV_STORE_ALL, NV_REST_ALL, NV_STORE_ONE, NV_REST_ONE
  } pfp_nv_op_e;
  typedef struct packed {
    pfp_nv_op_e op;
    logic [7:0] code;
  } pfp_nv_req_s;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] data;
  } pfp_wr_s;
endpackage : pfp_pkg
`default_nettype wire

// ### verif/pfp_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Port-level checks of the command core
module pfp_core_properties #(
  parameter int RESTART_CYC = 8
) (
  input wire logic core_clk, // Clock
  input wire logic resetn, // Reset, low
  input wire logic on_off_input_pin, // On/off pin
  input wire logic [3:0] fault_raw, // Faults
  input wire logic alert_oe, // Alert drive
  input wire pfp_pkg::pfp_wr_s ext_wr, // Outgoing write
  input wire logic ext_wr_vld, // Write strobe
  input wire pfp_pkg::pfp_nv_req_s nv_req, // EEPROM request
  input wire logic nv_req_vld, // Request strobe
  input wire logic nv_done, // EEPROM done
  input wire logic switch_en, // Drivers on
  input wire logic low_side_hold, // Restart hold
  input wire logic latched_off // Fault latch
);
  logic st_busy;
  int unsigned hcnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Store window seen from the strobes; starts a cycle after the core's, ends with it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) st_busy <= 1'b0;
    else if (nv_req_vld && !nv_req.op[0]) st_busy <= 1'b1;
    else if (nv_done) st_busy <= 1'b0;
  end
  // Length of the current low-side hold
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) hcnt <= 0;
    else if (low_side_hold) hcnt <= hcnt + 1;
    else hcnt <= 0;
  end
  sequence s_rest_on;
    nv_req_vld && (nv_req.op inside {pfp_pkg::NV_REST_ALL, pfp_pkg::NV_REST_ONE}) &&
      $past(switch_en);
  endsequence
  sequence s_held;
    !switch_en && low_side_hold;
  endsequence
  sequence s_rest_latched;
    nv_req_vld && nv_req.op[0] && $past(latched_off);
  endsequence
  sequence s_resumed;
    !latched_off && switch_en;
  endsequence
  AST_OFF_PIN_STOPS: assert property (!on_off_input_pin [*4] |-> !switch_en)
    else $error("switching kept while on/off pin off");
  AST_FAULT_ALERTS: assert property ((fault_raw != 4'h0 && !st_busy) [*3] |-> ##[0:4] alert_oe)
    else $error("standing fault without alert");
  AST_LATCH_HOLDS_OFF: assert property (latched_off |-> !switch_en)
    else $error("latched unit is switching");
  AST_RESTORE_STOPS: assert property (s_rest_on |-> ##[0:4] s_held)
    else $error("restore while switching did not stop");
  AST_HOLD_SPAN: assert property ($fell(low_side_hold) |-> hcnt >= RESTART_CYC - 1 && hcnt <= RESTART_CYC + 1)
    else $error("low side hold of wrong length");
  AST_STORE_KEEPS_ON: assert property ((st_busy && switch_en && on_off_input_pin) [*4] |=> switch_en)
    else $error("switching stopped during store");
  AST_STORE_QUIET: assert property (st_busy && !nv_done && !alert_oe |=> !alert_oe)
    else $error("alert raised during store");
  AST_LATCH_RESUME: assert property (s_rest_latched |-> ##[1:60] s_resumed)
    else $error("restore did not resume latched unit");
  AST_INTERNAL_WRITE: assert property (ext_wr_vld |-> !(ext_wr.code inside {8'h02, 8'h03, [8'h10:8'h14]}))
    else $error("internal code leaked as outgoing write");
endmodule : pfp_core_properties
bind pfp_core pfp_core_properties #(.RESTART_CYC(RESTART_CYC)) u_props (
  .core_clk(core_clk), .resetn(resetn), .on_off_input_pin(on_off_input_pin),
  .fault_raw(fault_raw), .alert_oe(alert_oe), .ext_wr(ext_wr), .ext_wr_vld(ext_wr_vld),
  .nv_req(nv_req), .nv_req_vld(nv_req_vld), .nv_done(nv_done), .switch_en(switch_en),
  .low_side_hold(low_side_hold), .latched_off(latched_off)
);
`default_nettype wire

// ### verif/pfp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Bus host: drives the clock, pulls data low
module pfp_host_model #(
  parameter logic [6:0] ADDR = 7'h58
) (
  input wire logic core_clk, // Bench clock
  output logic scl, // Bus clock, idle high
  output logic sda_low, // Pulls data low
  input wire logic sda // Resolved data line
);
  int q = 2;
  // Clock stands high outside frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic t(input int n);
    repeat (n * q) @(negedge core_clk);
  endtask : t
  // Data set mid low phase, sampled mid high phase for slack
  task automatic bit_x(input logic b, output logic s);
    t(1);
    sda_low = !b;
    t(1);
    scl = 1'b1;
    t(1);
    s = sda;
    t(1);
    scl = 1'b0;
  endtask : bit_x
  task automatic byte_x(input logic [7:0] v, input logic m, output logic [7:0] r,
                        output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(v[i], s);
      r[i] = s;
    end
    bit_x(m, s);
    a = !s;
  endtask : byte_x
  // Start and repeated start
  task automatic start_x();
    t(1);
    sda_low = 1'b0;
    t(1);
    scl = 1'b1;
    t(2);
    sda_low = 1'b1;
    t(2);
    scl = 1'b0;
  endtask : start_x
  task automatic stop_x();
    t(1);
    sda_low = 1'b1;
    t(1);
    scl = 1'b1;
    t(2);
    sda_low = 1'b0;
    t(4);
  endtask : stop_x
  // Kind 0 send byte, 1 write byte, 2 read byte; ok is the address ack
  task automatic xfer(input logic [1:0] k, input logic [7:0] c, d, output logic [7:0] r,
                      output logic ok);
    logic [7:0] x;
    logic a;
    r = 8'h00;
    start_x();
    byte_x({ADDR, 1'b0}, 1'b1, x, ok);
    if (ok) begin
      byte_x(c, 1'b1, x, a);
      if (k == 2'd1) byte_x(d, 1'b1, x, a);
      if (k == 2'd2) begin
        start_x();
        byte_x({ADDR, 1'b1}, 1'b1, x, a);
        byte_x(8'hFF, 1'b1, r, a);
      end
    end
    stop_x();
  endtask : xfer
endmodule : pfp_host_model
`default_nettype wire

// ### verif/pfp_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module pfp_core_test;
  localparam int RC = 8;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic on_off_pin = 1'b1;
  logic op_on = 1'b0;
  logic latch_mode = 1'b0;
  logic [3:0] fault_raw = 4'h0;
  logic [7:0] ext_rdata = 8'h5A;
  logic nv_done = 1'b0;
  logic nv_fail = 1'b0;
  logic fail_next = 1'b0;
  logic [7:0] nv_rdata = 8'h00;
  logic scl, h_low, sda_out, sda_oe, alert_oe, ext_wr_vld, nv_req_vld;
  logic switch_en, low_side_hold, latched_off, ak;
  logic [7:0] rv;
  wire logic sda_w;
  pfp_pkg::pfp_wr_s ext_wr, wr_last;
  pfp_pkg::pfp_nv_req_s nv_req, nv_last;
  int err_count = 0, n_checks = 0, wr_n = 0, nv_n = 0;
  // Open-drain data line with pull-up
  assign sda_w = !(h_low || (sda_oe && !sda_out));
  always #12.5 core_clk = ~core_clk;
  pfp_core #(.RESTART_CYC(RC)) dut (
    .core_clk(core_clk), .resetn(resetn), .clk_en(1'b1), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .alert_oe(alert_oe), .on_off_input_pin(on_off_pin),
    .op_on(op_on), .latch_mode(latch_mode), .fault_raw(fault_raw), .ext_rdata(ext_rdata),
    .ext_wr(ext_wr), .ext_wr_vld(ext_wr_vld), .nv_req(nv_req), .nv_req_vld(nv_req_vld),
    .nv_done(nv_done), .nv_fail(nv_fail), .nv_rdata(nv_rdata), .switch_en(switch_en),
    .low_side_hold(low_side_hold), .latched_off(latched_off)
  );
  pfp_host_model host (.core_clk(core_clk), .scl(scl), .sda_low(h_low), .sda(sda_w));
  // Count strobes; pre-edge values are read, so no race with the core
  always @(posedge core_clk) begin
    if (ext_wr_vld) begin
      wr_n++;
      wr_last = ext_wr;
    end
    if (nv_req_vld) begin
      nv_n++;
      nv_last = nv_req;
    end
  end
  // EEPROM side: slow answer so a store spans several bus phases
  always begin
    @(posedge core_clk iff nv_req_vld);
    repeat (20) @(negedge core_clk);
    nv_fail = fail_next;
    nv_done = 1'b1;
    @(negedge core_clk);
    nv_done = 1'b0;
    nv_fail = 1'b0;
    fail_next = 1'b0;
  end
  // ======
  // Helpers
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [15:0] g, e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic bus(input logic [1:0] k, input logic [7:0] c, d);
    host.xfer(k, c, d, rv, ak);
  endtask : bus
  task automatic rchk(input logic [7:0] c, e);
    bus(2'd2, c, 8'h00);
    chk($sformatf("read %h", c), {8'h00, rv}, {8'h00, e});
  endtask : rchk
  // ======
  // Scenarios
  task automatic t_reset();
    host.q = 4;
    rchk(8'h10, 8'h00);
    host.q = 2;
    rchk(8'h02, 8'h17);
    bus(2'd1, 8'h02, 8'h16);
    rchk(8'h02, 8'h17);
    rchk(8'h78, 8'h00);
    $display("test reset_values done");
  endtask : t_reset
  task automatic t_guard();
    logic [7:0] g [3] = '{8'h20, 8'h40, 8'h80};
    int w0;
    for (int i = 0; i < 3; i++) begin
      bus(2'd1, 8'h10, g[i]);
      rchk(8'h10, g[i]);
      rchk(8'h22, 8'h5A);
      w0 = wr_n;
      bus(2'd1, 8'h01, 8'h80);
      bus(2'd1, 8'h22, 8'h00);
      chk("ext writes", 16'(wr_n - w0), 16'(i < 2));
      chk("ext write", 16'(wr_last), 16'h0180);
      bus(2'd1, 8'h02, 8'h14);
      rchk(8'h02, (i == 0) ? 8'h15 : 8'h17);
      rchk(8'h78, 8'h02);
      bus(2'd1, 8'h10, 8'h00);
      bus(2'd0, 8'h03, 8'h00);
      bus(2'd1, 8'h02, 8'h16);
    end
    $display("test guard_modes done");
  endtask : t_guard
  task automatic t_bad_guard();
    bus(2'd1, 8'h10, 8'h60);
    rchk(8'h10, 8'h00);
    rchk(8'h78, 8'h02);
    rchk(8'h7E, 8'h40);
    chk("alert", 16'(alert_oe), 16'h1);
    bus(2'd0, 8'h03, 8'h00);
    chk("alert", 16'(alert_oe), 16'h0);
    rchk(8'h7E, 8'h00);
    rchk(8'h78, 8'h00);
    $display("test bad_guard done");
  endtask : t_bad_guard
  task automatic t_persist();
    fault_raw = 4'h1;
    cyc(4);
    bus(2'd0, 8'h03, 8'h00);
    rchk(8'h78, 8'h04);
    chk("alert", 16'(alert_oe), 16'h1);
    fault_raw = 4'h0;
    bus(2'd0, 8'h03, 8'h00);
    rchk(8'h78, 8'h00);
    $display("test persist done");
  endtask : t_persist
  task automatic t_store();
    int n0 = nv_n;
    bus(2'd0, 8'h11, 8'h00);
    cyc(2);
    chk("store req", 16'(nv_n - n0), 16'h1);
    chk("store op", 16'(nv_last.op), 16'(pfp_pkg::NV_STORE_ALL));
    fault_raw = 4'h2;
    cyc(4);
    chk("alert", 16'(alert_oe), 16'h0);
    chk("switching", 16'(switch_en), 16'h1);
    fault_raw = 4'h0;
    cyc(30);
    rchk(8'h78, 8'h00);
    fail_next = 1'b1;
    bus(2'd0, 8'h11, 8'h00);
    cyc(30);
    bus(2'd2, 8'h78, 8'h00);
    chk("nack", 16'(ak), 16'h0);
    rchk(8'h78, 8'h02);
    rchk(8'h7E, 8'h02);
    bus(2'd0, 8'h03, 8'h00);
    $display("test store done");
  endtask : t_store
  task automatic t_one();
    int n0;
    on_off_pin = 1'b0;
    cyc(6);
    chk("switch off", 16'(switch_en), 16'h0);
    bus(2'd1, 8'h13, 8'h10);
    cyc(30);
    chk("store one", 16'(nv_last), 16'({pfp_pkg::NV_STORE_ONE, 8'h10}));
    on_off_pin = 1'b1;
    cyc(10);
    nv_rdata = 8'h40;
    bus(2'd1, 8'h14, 8'h10);
    for (int i = 0; i < 20 && low_side_hold !== 1'b1; i++) cyc(1);
    chk("hold", 16'(low_side_hold), 16'h1);
    chk("switch stop", 16'(switch_en), 16'h0);
    cyc(60);
    chk("restart", 16'(switch_en), 16'h1);
    chk("restore one", 16'(nv_last), 16'({pfp_pkg::NV_REST_ONE, 8'h10}));
    rchk(8'h10, 8'h40);
    bus(2'd1, 8'h10, 8'h00);
    nv_rdata = 8'h00;
    n0 = nv_n;
    bus(2'd1, 8'h13, 8'h78);
    bus(2'd1, 8'h14, 8'h55);
    chk("refused", 16'(nv_n - n0), 16'h0);
    rchk(8'h7E, 8'h40);
    bus(2'd0, 8'h03, 8'h00);
    $display("test single_code done");
  endtask : t_one
  task automatic t_latch();
    latch_mode = 1'b1;
    fault_raw = 4'h1;
    cyc(8);
    fault_raw = 4'h0;
    bus(2'd0, 8'h03, 8'h00);
    chk("stays off", 16'({latched_off, switch_en}), 16'h2);
    bus(2'd0, 8'h12, 8'h00); // converter already stopped
    for (int i = 0; i < 80 && switch_en !== 1'b1; i++) cyc(1);
    chk("resumed", 16'({latched_off, switch_en}), 16'h1);
    chk("restore all", 16'(nv_last.op), 16'(pfp_pkg::NV_REST_ALL));
    latch_mode = 1'b0;
    $display("test latch done");
  endtask : t_latch
  // Watchdog: about four times the expected run
  initial begin
    #2000000;
    err_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    cyc(8);
    t_reset();
    t_guard();
    t_bad_guard();
    t_persist();
    t_store();
    t_one();
    t_latch();
    end_sim();
  end
endmodule : pfp_core_test
`default_nettype wire
